// *** rtl/mww_pkg.sv ***
package mww_pkg;
    // timing base
    localparam int CLK_PERIOD_NS = 20;
    localparam int STEP_TIME_NS = 550_000;
    localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
    localparam int RESET_EXT_NS = 1_440_000;
    localparam int RESET_EXT_CYCLES = (RESET_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELF_TEST_NS = 21_000_000;
    localparam int SELF_TEST_CYCLES = SELF_TEST_NS / CLK_PERIOD_NS;

    // widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int WIN_W = 5;
    localparam int FAIL_W = 3;

    // fail counter landmarks
    localparam logic [FAIL_W-1:0] FAIL_MIN = 3'h0;
    localparam logic [FAIL_W-1:0] FAIL_STEP = 3'h1;
    localparam logic [FAIL_W-1:0] FAIL_IN_RANGE_MAX = 3'h4;
    localparam logic [FAIL_W-1:0] FAIL_PRE_MAX = 3'h6;
    localparam logic [FAIL_W-1:0] FAIL_MAX = 3'h7;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_SAFETY_CFG = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_WIN_ONE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_WIN_TWO = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_WD_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_CHECK_CTRL = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_SELF_TEST = 8'h14;

    // field positions
    localparam int CFG_WATCHDOG_ENABLE_BIT_BIT = 2;
    localparam int CFG_RST_ON_FAIL_BIT = 3;
    localparam int CFG_MODE_BIT = 5;
    localparam int STAT_OOR_BIT = 0;
    localparam int STAT_TIMEOUT_BIT = 1;
    localparam int STAT_FAIL_LSB = 4;
    localparam int CHECK_DRV_EN_BIT = 0;
    localparam int SELF_TEST_BIT = 0;

    // reset values
    localparam logic [DATA_W-1:0] SAFETY_CFG_RST = 8'h0C;
    localparam logic [WIN_W-1:0] WIN_ONE_RST = 5'h0F;
    localparam logic [WIN_W-1:0] WIN_TWO_RST = 5'h1F;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 8'h00;

    typedef enum logic {MWW_MODE_PIN, MWW_MODE_QA} mww_mode_t;

    typedef enum logic [1:0] {ST_HOLD, ST_CLOSE, ST_OPEN, ST_SUSPEND} mww_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } mww_bus_t;
endpackage : mww_pkg

// *** rtl/mww_pin_sync.sv ***
`timescale 1ns/1ps
module mww_pin_sync
(
    // clock and reset
    input logic clk_sys,
    input logic nrst,
    // pin
    input logic pinIn,
    // event
    output logic trigPulse
);
    import mww_pkg::*;

    logic [1:0] sync_q;
    logic level_q;
    logic armed_q;
    logic trig_q;
    wire rise = sync_q[1] & ~level_q;
    wire fall = ~sync_q[1] & level_q;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_q <= 2'h0;
            level_q <= 1'b0;
            armed_q <= 1'b0;
            trig_q <= 1'b0;
        end
        else
        begin
            sync_q <= {sync_q[0], pinIn};
            level_q <= sync_q[1];
            // a trigger is a rising edge and then a falling edge
            armed_q <= rise | (armed_q & ~fall);
            trig_q <= fall & armed_q;
        end
    end

    assign trigPulse = trig_q;
endmodule : mww_pin_sync

// *** rtl/mww_window_timer.sv ***
`timescale 1ns/1ps
module mww_window_timer #(
    parameter int STEP_CYC = mww_pkg::STEP_CYCLES,
    parameter int WIN_W = mww_pkg::WIN_W
)
(
    // clock and reset
    input logic clk_sys,
    input logic nrst,
    // control
    input logic start,
    input logic stop,
    input logic [WIN_W-1:0] steps,
    // status
    output logic expire
);
    import mww_pkg::*;

    localparam int PRE_W = $clog2(STEP_CYC);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYC - 1);
    localparam logic [PRE_W-1:0] PRE_ZERO = PRE_W'(0);
    localparam logic [WIN_W-1:0] STEP_ZERO = WIN_W'(0);
    localparam logic [WIN_W-1:0] STEP_ONE = WIN_W'(1);

    logic [PRE_W-1:0] pre_q;
    logic [WIN_W-1:0] step_q;
    logic run_q;
    wire stepTick = run_q & (pre_q == PRE_LAST);

    // a window lasts (steps + 1) time steps of STEP_CYC cycles
    assign expire = stepTick & (step_q == STEP_ZERO);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pre_q <= PRE_ZERO;
            step_q <= STEP_ZERO;
            run_q <= 1'b0;
        end
        else if (start)
        begin
            pre_q <= PRE_ZERO;
            step_q <= steps;
            run_q <= 1'b1;
        end
        else if (stop || expire)
        begin
            pre_q <= PRE_ZERO;
            run_q <= 1'b0;
        end
        else if (run_q)
        begin
            // step base derived from the system clock
            pre_q <= stepTick ? PRE_ZERO : pre_q + PRE_W'(1);
            if (stepTick)
            begin
                step_q <= step_q - STEP_ONE;
            end
        end
    end
endmodule : mww_window_timer

// *** rtl/mww_watchdog.sv ***
`timescale 1ns/1ps
module mww_watchdog #(
    parameter int STEP_CYC = mww_pkg::STEP_CYCLES,
    parameter int RESET_EXT_CYC = mww_pkg::RESET_EXT_CYCLES,
    parameter int SELF_TEST_CYC = mww_pkg::SELF_TEST_CYCLES
)
(
    // clock and reset
    input logic clk_sys,
    input logic nrst,
    // register port
    input mww_pkg::mww_bus_t busReq,
    output logic [mww_pkg::DATA_W-1:0] busRdata_q,
    // microcontroller pins
    input logic mcuErrorTriggerIn,
    output logic mcuResetOutN_q,
    // power stage
    output logic powerStageEnableOut_q
);
    import mww_pkg::*;

    localparam int HOLD_MAX = (SELF_TEST_CYC > RESET_EXT_CYC) ? SELF_TEST_CYC : RESET_EXT_CYC;
    localparam int HOLD_W = $clog2(HOLD_MAX);
    localparam logic [HOLD_W-1:0] HOLD_ZERO = HOLD_W'(0);
    localparam logic [HOLD_W-1:0] HOLD_ONE = HOLD_W'(1);
    localparam logic [HOLD_W-1:0] HOLD_RST_LAST = HOLD_W'(RESET_EXT_CYC - 1);
    localparam logic [HOLD_W-1:0] HOLD_TEST_LAST = HOLD_W'(SELF_TEST_CYC - 1);

    // registers
    logic [DATA_W-1:0] cfg_q;
    logic [WIN_W-1:0] winOne_q;
    logic [WIN_W-1:0] winTwo_q;
    logic drvEn_q;
    logic timeout_q;
    logic timeout_d;
    logic [FAIL_W-1:0] fail_q;
    logic [FAIL_W-1:0] fail_d;
    mww_state_t state_q;
    mww_state_t state_d;
    logic [HOLD_W-1:0] hold_q;
    logic [WIN_W-1:0] closeLat_q;
    logic [WIN_W-1:0] openLat_q;
    logic sawTrig_q;
    logic [DATA_W-1:0] rdata_d;

    // address decode
    wire hitCfg = busReq.addr == ADDR_SAFETY_CFG;
    wire hitWinOne = busReq.addr == ADDR_WIN_ONE;
    wire hitWinTwo = busReq.addr == ADDR_WIN_TWO;
    wire hitStatus = busReq.addr == ADDR_WD_STATUS;
    wire hitCheck = busReq.addr == ADDR_CHECK_CTRL;
    wire hitSelfTest = busReq.addr == ADDR_SELF_TEST;
    wire wrCfg = busReq.wr & hitCfg;
    wire wrWinOne = busReq.wr & hitWinOne;
    wire wrWinTwo = busReq.wr & hitWinTwo;
    wire wrStatus = busReq.wr & hitStatus;
    wire wrCheck = busReq.wr & hitCheck;
    wire wrSelfTest = busReq.wr & hitSelfTest;

    // configuration fields, range status and write strobes
    wire wdEn = cfg_q[CFG_WATCHDOG_ENABLE_BIT_BIT];
    wire rstOnFail = cfg_q[CFG_RST_ON_FAIL_BIT];
    wire pinMode = mww_mode_t'(cfg_q[CFG_MODE_BIT]) == MWW_MODE_PIN;
    wire outOfRange = fail_q > FAIL_IN_RANGE_MAX;
    wire toClear = wrStatus & busReq.wdata[STAT_TIMEOUT_BIT];
    wire stStart = wrSelfTest & busReq.wdata[SELF_TEST_BIT];

    // trigger input
    logic trigPulse;
    mww_pin_sync u_pin_sync
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pinIn(mcuErrorTriggerIn),
        .trigPulse(trigPulse)
    );

    // serial answer checking is not built: only pin mode produces events
    wire trigUse = trigPulse & pinMode;
    wire inClose = state_q == ST_CLOSE;
    wire inOpen = state_q == ST_OPEN;
    wire inHold = state_q == ST_HOLD;
    wire inSuspend = state_q == ST_SUSPEND;

    // window timer
    logic winExpire;
    wire startClose = (state_d == ST_CLOSE) & (~inClose | (inOpen & trigUse));
    wire startOpen = (state_d == ST_OPEN) & ~inOpen;
    wire winStop = (state_d == ST_HOLD) | (state_d == ST_SUSPEND);
    wire winStart = startClose | startOpen;
    wire [WIN_W-1:0] winSteps = startOpen ? openLat_q : closeLat_q;

    mww_window_timer #(
        .STEP_CYC(STEP_CYC),
        .WIN_W(WIN_W)
    ) u_window_timer
    (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .start(winStart),
        .stop(winStop),
        .steps(winSteps),
        .expire(winExpire)
    );

    // events; self-test and reset hold see none
    wire badEv = inClose & trigUse;
    wire goodEv = inOpen & trigUse;
    wire toEv = inOpen & winExpire & ~trigUse & ~sawTrig_q & pinMode;
    wire failUp = badEv | toEv;
    wire failDn = goodEv;
    wire rstFail = failUp & (fail_q == FAIL_PRE_MAX) & rstOnFail;
    wire holdLast = inHold ? (hold_q == HOLD_RST_LAST) : (hold_q == HOLD_TEST_LAST);

    // fail counter with saturation, independent of the enable bit
    always_comb
    begin
        fail_d = fail_q;
        if (failUp && !failDn && fail_q != FAIL_MAX)
        begin
            fail_d = fail_q + FAIL_STEP;
        end
        else if (failDn && !failUp && fail_q != FAIL_MIN)
        begin
            fail_d = fail_q - FAIL_STEP;
        end
    end

    // time-out flag: a set in the clearing cycle wins
    assign timeout_d = toEv | (timeout_q & ~toClear);

    // window sequencer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_HOLD:
            begin
                if (holdLast)
                begin
                    state_d = ST_CLOSE;
                end
            end
            ST_CLOSE:
            begin
                if (winExpire)
                begin
                    state_d = ST_OPEN;
                end
            end
            ST_OPEN:
            begin
                // trigger or expiry, whichever first, restarts a close window
                if (trigUse || winExpire)
                begin
                    state_d = ST_CLOSE;
                end
            end
            ST_SUSPEND:
            begin
                if (holdLast)
                begin
                    state_d = ST_CLOSE;
                end
            end
            default:
            begin
                state_d = ST_HOLD;
            end
        endcase
        if (rstFail)
        begin
            state_d = ST_HOLD;
        end
        else if (stStart && !inHold)
        begin
            state_d = ST_SUSPEND;
        end
    end

    // read mux
    always_comb
    begin
        rdata_d = RDATA_ZERO;
        if (hitCfg)
        begin
            rdata_d = cfg_q;
        end
        else if (hitWinOne)
        begin
            rdata_d = {{(DATA_W - WIN_W){1'b0}}, winOne_q};
        end
        else if (hitWinTwo)
        begin
            rdata_d = {{(DATA_W - WIN_W){1'b0}}, winTwo_q};
        end
        else if (hitStatus)
        begin
            rdata_d[STAT_OOR_BIT] = outOfRange;
            rdata_d[STAT_TIMEOUT_BIT] = timeout_q;
            rdata_d[STAT_FAIL_LSB +: FAIL_W] = fail_q;
        end
        else if (hitCheck)
        begin
            rdata_d[CHECK_DRV_EN_BIT] = drvEn_q;
        end
        else if (hitSelfTest)
        begin
            rdata_d[SELF_TEST_BIT] = inSuspend;
        end
    end

    // software registers
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cfg_q <= SAFETY_CFG_RST;
            winOne_q <= WIN_ONE_RST;
            winTwo_q <= WIN_TWO_RST;
            drvEn_q <= 1'b0;
        end
        else
        begin
            if (wrCfg)
            begin
                cfg_q <= busReq.wdata;
            end
            if (wrWinOne)
            begin
                winOne_q <= busReq.wdata[WIN_W-1:0];
            end
            if (wrWinTwo)
            begin
                winTwo_q <= busReq.wdata[WIN_W-1:0];
            end
            if (wrCheck)
            begin
                drvEn_q <= busReq.wdata[CHECK_DRV_EN_BIT];
            end
        end
    end

    // watchdog state
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ST_HOLD;
            fail_q <= FAIL_MIN;
            timeout_q <= 1'b0;
            hold_q <= HOLD_ZERO;
            sawTrig_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            fail_q <= fail_d;
            timeout_q <= timeout_d;
            hold_q <= (state_d != state_q) ? HOLD_ZERO : hold_q + HOLD_ONE;
            sawTrig_q <= startClose ? 1'b0 : (sawTrig_q | badEv);
        end
    end

    // durations are latched so that updates wait for the next window
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            closeLat_q <= WIN_ONE_RST;
            openLat_q <= WIN_TWO_RST;
        end
        else
        begin
            if (inHold || inSuspend || startOpen)
            begin
                closeLat_q <= winOne_q;
            end
            if (startClose)
            begin
                openLat_q <= winTwo_q;
            end
        end
    end

    // outputs
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            busRdata_q <= RDATA_ZERO;
            mcuResetOutN_q <= 1'b0;
            powerStageEnableOut_q <= 1'b0;
        end
        else
        begin
            busRdata_q <= busReq.rd ? rdata_d : RDATA_ZERO;
            mcuResetOutN_q <= state_d != ST_HOLD;
            powerStageEnableOut_q <= drvEn_q & ~(wdEn & outOfRange);
        end
    end

    property p_good_dec;
        @(posedge clk_sys) disable iff (!nrst)
        (goodEv && fail_q != FAIL_MIN) |=> fail_q == $past(fail_q) - FAIL_STEP;
    endproperty
    a_good_dec: assert property (p_good_dec)
        else $error("good event did not lower the fail count");

    property p_bad_inc;
        @(posedge clk_sys) disable iff (!nrst)
        (badEv && fail_q != FAIL_MAX) |=> fail_q == $past(fail_q) + FAIL_STEP;
    endproperty
    a_bad_inc: assert property (p_bad_inc)
        else $error("bad event did not raise the fail count");

    property p_timeout;
        @(posedge clk_sys) disable iff (!nrst)
        (toEv && fail_q != FAIL_MAX) |=> timeout_q && fail_q == $past(fail_q) + FAIL_STEP;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("time-out did not set flag and raise count");

    property p_oor_low;
        @(posedge clk_sys) disable iff (!nrst)
        (wdEn && fail_q > FAIL_IN_RANGE_MAX) |=> !powerStageEnableOut_q;
    endproperty
    a_oor_low: assert property (p_oor_low)
        else $error("enable output high while out of range");

    property p_in_range;
        @(posedge clk_sys) disable iff (!nrst)
        (drvEn_q && fail_q <= FAIL_IN_RANGE_MAX)[*2] |=> powerStageEnableOut_q;
    endproperty
    a_in_range: assert property (p_in_range)
        else $error("enable output low while in range");

    property p_wd_off;
        @(posedge clk_sys) disable iff (!nrst)
        (!wdEn && drvEn_q && fail_q > FAIL_IN_RANGE_MAX) |=> powerStageEnableOut_q;
    endproperty
    a_wd_off: assert property (p_wd_off)
        else $error("enable output forced low with watchdog disabled");

    property p_saturate;
        @(posedge clk_sys) disable iff (!nrst)
        (fail_q == FAIL_MAX && failUp) |=> fail_q == FAIL_MAX;
    endproperty
    a_saturate: assert property (p_saturate)
        else $error("fail count wrapped above seven");

    property p_fail_reset;
        @(posedge clk_sys) disable iff (!nrst)
        rstFail |=> !mcuResetOutN_q ##1 !mcuResetOutN_q;
    endproperty
    a_fail_reset: assert property (p_fail_reset)
        else $error("reset not pulled low on reaching seven");

    property p_rise_close;
        @(posedge clk_sys) disable iff (!nrst)
        $rose(mcuResetOutN_q) |-> inClose && $past(inHold);
    endproperty
    a_rise_close: assert property (p_rise_close)
        else $error("reset release not followed by close window");

    property p_open_trig;
        @(posedge clk_sys) disable iff (!nrst)
        (inOpen && trigUse && !rstFail && !stStart) |=> inClose ##1 inClose;
    endproperty
    a_open_trig: assert property (p_open_trig)
        else $error("trigger in open window did not restart close");

    property p_suspend;
        @(posedge clk_sys) disable iff (!nrst)
        inSuspend |-> (!failUp && !failDn) ##1 $stable(fail_q);
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("monitoring active during self-test");
endmodule : mww_watchdog

// *** bench/mww_mcu_model.sv ***
`timescale 1ns/1ps
module mww_mcu_model
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // command from the bench
    input wire logic fireReq,
    input wire logic [3:0] highCyc,
    // trigger pin
    output logic pinOut
);
    logic [3:0] holdCnt;

    // one trigger is a rise, a held high level, then a fall
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pinOut <= 1'b0;
            holdCnt <= 4'h0;
        end
        else if (fireReq && !pinOut)
        begin
            pinOut <= 1'b1;
            holdCnt <= highCyc;
        end
        else if (holdCnt != 4'h0)
            holdCnt <= holdCnt - 4'h1;
        else
            pinOut <= 1'b0;
    end
endmodule : mww_mcu_model

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin nErrors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
    import mww_pkg::*;
    localparam int STEP = 20;
    localparam int WIN = 2 * STEP;
    localparam logic [7:0] CLR = 8'h01 << STAT_TIMEOUT_BIT;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    mww_bus_t busReq = '0;
    logic [7:0] busRdata_q;
    logic pin;
    logic resetN;
    logic enOut;
    logic fireReq = 1'b0;
    int nErrors = 0;
    int compares = 0;
    int cyc = 0;
    logic [7:0] d;
    logic [2:0] c;

    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc++;

    mww_watchdog #(.STEP_CYC(STEP), .RESET_EXT_CYC(16), .SELF_TEST_CYC(40)) mww_watchdog_i (
        .clk_sys(clk_sys), .nrst(nrst), .busReq(busReq), .busRdata_q(busRdata_q),
        .mcuErrorTriggerIn(pin), .mcuResetOutN_q(resetN), .powerStageEnableOut_q(enOut));
    mww_mcu_model mww_mcu_model_i (.clk_sys(clk_sys), .nrst(nrst), .fireReq(fireReq),
        .highCyc(4'h3), .pinOut(pin));

    function automatic logic [2:0] fc(input logic [7:0] v);
        return v[STAT_FAIL_LSB +: FAIL_W];
    endfunction : fc

    task automatic close_out;
        $display("compares %0d errors %0d", compares, nErrors);
        if (nErrors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    task automatic fin(input string s);
        $display("test %s done", s);
    endtask : fin

    task automatic waitc(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : waitc

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        busReq <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        busReq <= '0;
        @(negedge clk_sys);
        v = busRdata_q;
    endtask : rd

    task automatic fire;
        @(posedge clk_sys);
        fireReq <= 1'b1;
        @(posedge clk_sys);
        fireReq <= 1'b0;
    endtask : fire

    // wait for the time-out flag before any trigger, then clear it
    task automatic sync;
        int t0;
        t0 = cyc;
        d = 8'h00;
        while (d[STAT_TIMEOUT_BIT] !== 1'b1)
        begin
            if (cyc - t0 > 600)
            begin
                `CHK(1'b0, 1'b1)
                close_out();
            end
            rd(ADDR_WD_STATUS, d);
        end
        wr(ADDR_WD_STATUS, CLR);
    endtask : sync

    task automatic t_reset;
        int t0;
        `CHK(resetN, 1'b0)
        `CHK(enOut, 1'b0)
        @(posedge clk_sys);
        nrst <= 1'b1;
        t0 = cyc;
        rd(ADDR_SAFETY_CFG, d);
        `CHK(d[CFG_MODE_BIT], 1'b0)
        rd(ADDR_WIN_ONE, d);
        `CHK(d[4:0], WIN_ONE_RST)
        rd(ADDR_WIN_TWO, d);
        `CHK(d[4:0], WIN_TWO_RST)
        rd(8'h3C, d);
        `CHK(d, RDATA_ZERO)
        while (resetN !== 1'b1 && cyc - t0 < 100)
            @(negedge clk_sys);
        `CHK((cyc - t0) inside {[16:18]}, 1'b1)
        if (resetN !== 1'b1)
        begin
            close_out();
        end
        fin("reset");
    endtask : t_reset

    // trigger in the first open window at count zero
    task automatic t_early;
        wr(ADDR_WIN_ONE, 8'h01);
        wr(ADDR_WIN_TWO, 8'h01);
        waitc(400);
        fire();
        waitc(12);
        rd(ADDR_WD_STATUS, d);
        `CHK(fc(d), FAIL_MIN)
        `CHK(d[STAT_TIMEOUT_BIT], 1'b0)
        fin("early");
    endtask : t_early

    task automatic t_period;
        int t0;
        sync();
        sync();
        t0 = cyc;
        sync();
        `CHK((cyc - t0) inside {[2*WIN-4:2*WIN+4]}, 1'b1)
        rd(ADDR_WD_STATUS, d);
        `CHK(fc(d), 3'h3)
        `CHK(d[STAT_OOR_BIT], 1'b0)
        fin("period");
    endtask : t_period

    task automatic t_good;
        sync();
        rd(ADDR_WD_STATUS, d);
        c = fc(d);
        waitc(WIN);
        fire();
        waitc(12);
        rd(ADDR_WD_STATUS, d);
        `CHK(fc(d), c - 3'h1)
        fin("good");
    endtask : t_good

    task automatic t_bad;
        wr(ADDR_CHECK_CTRL, 8'h01);
        waitc(2);
        `CHK(enOut, 1'b1)
        sync();
        rd(ADDR_WD_STATUS, d);
        c = fc(d);
        fire();
        waitc(12);
        rd(ADDR_WD_STATUS, d);
        `CHK(fc(d), c + 3'h1)
        `CHK(d[STAT_OOR_BIT], 1'b1)
        `CHK(enOut, 1'b0)
        fin("bad");
    endtask : t_bad

    task automatic t_wden;
        wr(ADDR_SAFETY_CFG, SAFETY_CFG_RST & ~(8'h01 << CFG_WATCHDOG_ENABLE_BIT_BIT));
        waitc(2);
        `CHK(enOut, 1'b1)
        sync();
        rd(ADDR_WD_STATUS, d);
        `CHK(fc(d), FAIL_PRE_MAX)
        wr(ADDR_SAFETY_CFG, SAFETY_CFG_RST);
        waitc(2);
        `CHK(enOut, 1'b0)
        fin("wden");
    endtask : t_wden

    task automatic t_rst7;
        sync();
        waitc(0);
        `CHK(resetN, 1'b0)
        sync();
        rd(ADDR_WD_STATUS, d);
        `CHK(fc(d), FAIL_MAX)
        fin("rst7");
    endtask : t_rst7

    task automatic t_modes;
        wr(ADDR_SAFETY_CFG, SAFETY_CFG_RST | (8'h01 << CFG_MODE_BIT));
        wr(ADDR_WD_STATUS, CLR);
        repeat (6)
        begin
            fire();
            waitc(30);
        end
        rd(ADDR_WD_STATUS, d);
        `CHK(fc(d), FAIL_MAX)
        `CHK(d[STAT_TIMEOUT_BIT], 1'b0)
        wr(ADDR_SAFETY_CFG, SAFETY_CFG_RST);
        wr(ADDR_SELF_TEST, 8'h01);
        rd(ADDR_SELF_TEST, d);
        `CHK(d[SELF_TEST_BIT], 1'b1)
        waitc(60);
        rd(ADDR_SELF_TEST, d);
        `CHK(d[SELF_TEST_BIT], 1'b0)
        fin("modes");
    endtask : t_modes

    initial
    begin
        repeat (3) @(posedge clk_sys);
        t_reset();
        t_early();
        t_period();
        t_good();
        t_bad();
        t_wden();
        t_rst7();
        t_modes();
        close_out();
    end
endmodule : tb_top
